/* design/tlxo_core.sv */
// Purpose: executes table store, test-and-skip-if-zero and the two exclusive-or instructions
// Assumes: apb master on clock_in; data memory answers fr_rdata_in within the q2 clock
// Notes: one instruction cycle is four clocks, q1 to q4
// Notes on behaviour
// - table store opcode is sixteen bits; low two bits pick the pointer mode.
// - pointer low three bits pick which of eight holding registers gets the latch.
// - pointer kept, post-incremented, post-decremented or pre-incremented; no flags change.
// - table pointer is 21 bits, one byte address each over 2 Mbyte.
// - pointer bit 0 low picks low byte of word, high picks high byte.
// - table store is two cycles; latch read in q2, holding write in q4.
// - test register zero discards prefetched instruction, runs a no-op, two cycles.
// - skipping over a two-word instruction takes three cycles total.
// - access bit zero uses access bank, one uses the bank selector.
// - extended set, access bit zero, address up to 95 means indexed offset.
// - immediate xor updates working register in one cycle, sets negative and zero.
// - register xor stores to working register when d is 0, file when 1.
// - register xor reads q2, processes q3, writes q4, only negative and zero change.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module tlxo_core
    import tlxo_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // data memory file
    output logic [11:0] fr_addr_out,
    output logic fr_indexed_out,
    input wire logic [7:0] fr_rdata_in,
    output logic fr_wr_out,
    output logic [7:0] fr_wdata_out,
    // fetch and programming
    output logic flush_out,
    output logic prog_start_out
);
    function automatic tlxo_kind_t decode_kind(input logic [15:0] op);
        if (op[15:2] == OPC_TABLE_STORE)
            return TLXO_K_TSTORE;
        if (op[15:8] == OPC_XOR_IMM)
            return TLXO_K_XIMM;
        if (op[15:9] == OPC_TEST_SKIP)
            return TLXO_K_TSKIP;
        if (op[15:10] == OPC_XOR_REG)
            return TLXO_K_XREG;
        return TLXO_K_NONE;
    endfunction

    // file address from access bit, bank selector and the 8-bit file byte
    function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                              input logic [3:0] bank);
        if (a)
            return {bank, f};
        if (f <= ACCESS_SPLIT)
            return {ACCESS_LOW_BANK, f};
        return {ACCESS_HIGH_BANK, f};
    endfunction

    tlxo_hold_if hold_if ();

    tlxo_state_t state_q;
    tlxo_kind_t kind_q;
    logic [1:0] phase_q;
    logic [1:0] cyc_q;
    logic [1:0] total_q;
    logic [15:0] op_q;
    logic pend_q;
    logic ext_en_q;
    logic two_word_q;
    logic [3:0] bank_q;
    logic [7:0] wreg_q;
    logic [7:0] latch_q;
    logic [PTR_W-1:0] ptr_q;
    logic [7:0] operand_q;
    logic [7:0] result_q;
    logic neg_q;
    logic zero_q;
    logic skip_q;
    logic [1:0] last_cyc_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [11:0] fr_addr_q;
    logic fr_indexed_q;
    logic fr_wr_q;
    logic [7:0] fr_wdata_q;
    logic flush_q;
    logic prog_q;
    logic store_q;
    logic [7:0] store_data_q;

    // apb decode
    wire access_w = psel_in & penable_in & ~pready_q;
    wire commit_w = psel_in & penable_in & pready_q;
    wire wr_w = commit_w & pwrite_in;
    wire busy_w = pend_q | (state_q != TLXO_ST_IDLE);
    wire mapped_w = (paddr_in[1:0] == 2'b00) & (paddr_in <= ADDR_PROG);
    wire [31:0] status_w = {26'h0, last_cyc_q, skip_q, zero_q, neg_q, busy_w};
    wire [31:0] rd_mux_w =
        (paddr_in == ADDR_CTRL) ? {30'h0, two_word_q, ext_en_q} :
        (paddr_in == ADDR_BANK) ? {28'h0, bank_q} :
        (paddr_in == ADDR_WREG) ? {24'h0, wreg_q} :
        (paddr_in == ADDR_LATCH) ? {24'h0, latch_q} :
        (paddr_in == ADDR_POINTER) ? {11'h0, ptr_q} :
        (paddr_in == ADDR_INSTR) ? {16'h0, op_q} :
        (paddr_in == ADDR_STATUS) ? status_w :
        (paddr_in == ADDR_HOLD_LO) ? hold_if.contents[31:0] :
        (paddr_in == ADDR_HOLD_HI) ? hold_if.contents[63:32] : 32'h0;
    wire issue_w = wr_w & (paddr_in == ADDR_INSTR) & ~busy_w &
                   (decode_kind(pwdata_in[15:0]) != TLXO_K_NONE);

    // execution decode
    wire in_exec_w = (state_q == TLXO_ST_EXEC);
    wire start_w = pend_q & (state_q == TLXO_ST_IDLE) & (phase_q == PH_Q4);
    wire first_w = in_exec_w & (cyc_q == 2'h0);
    wire end_cyc_w = in_exec_w & (phase_q == PH_Q4);
    wire done_w = end_cyc_w & ((cyc_q + 2'h1) == total_q);
    wire is_file_w = (kind_q == TLXO_K_XREG) | (kind_q == TLXO_K_TSKIP);
    wire [1:0] mode_w = op_q[1:0];
    wire [7:0] xor_src_w = (kind_q == TLXO_K_XIMM) ? op_q[7:0] : operand_q;
    wire [7:0] xor_w = wreg_q ^ xor_src_w;
    wire xor_kind_w = (kind_q == TLXO_K_XIMM) | (kind_q == TLXO_K_XREG);
    wire xor_q4_w = first_w & xor_kind_w & (phase_q == PH_Q4);
    wire to_file_w = op_q[9];
    wire store_cyc_w = in_exec_w & (kind_q == TLXO_K_TSTORE) & (cyc_q == 2'h1);
    wire pre_inc_w = first_w & (phase_q == PH_Q4) & (kind_q == TLXO_K_TSTORE) &
                     (mode_w == MODE_PRE_INC);
    wire post_w = store_cyc_w & (phase_q == PH_Q4);
    wire indexed_w = ext_en_q & ~op_q[8] & (op_q[7:0] <= ACCESS_SPLIT);

    assign hold_if.store = store_q;
    assign hold_if.index = ptr_q[2:0];
    assign hold_if.data = store_data_q;

    tlxo_hold_bank u_hold (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .hold(hold_if)
    );

    // apb answer: one wait state so data comes from a flop
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= access_w;
            pslverr_q <= access_w & ~mapped_w;
            prdata_q <= (access_w & ~pwrite_in & mapped_w) ? rd_mux_w : 32'h0;
        end
    end

    // software registers
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            ext_en_q <= 1'b0;
            two_word_q <= 1'b0;
            bank_q <= 4'h0;
            latch_q <= BYTE_RESET;
            op_q <= 16'h0;
            pend_q <= 1'b0;
            prog_q <= 1'b0;
        end
        else
        begin
            prog_q <= wr_w & (paddr_in == ADDR_PROG) & pwdata_in[PROG_START_BIT];
            if (wr_w & (paddr_in == ADDR_CTRL))
            begin
                ext_en_q <= pwdata_in[CTRL_EXT_BIT];
                two_word_q <= pwdata_in[CTRL_TWO_WORD_BIT];
            end
            if (wr_w & (paddr_in == ADDR_BANK))
                bank_q <= pwdata_in[3:0];
            if (wr_w & (paddr_in == ADDR_LATCH))
                latch_q <= pwdata_in[7:0];
            if (issue_w)
            begin
                op_q <= pwdata_in[15:0];
                pend_q <= 1'b1;
            end
            else if (start_w)
                pend_q <= 1'b0;
        end
    end

    // sequencer over q phases and instruction cycles
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            state_q <= TLXO_ST_IDLE;
            phase_q <= PH_Q1;
            kind_q <= TLXO_K_NONE;
            cyc_q <= 2'h0;
            total_q <= CYC_ONE;
            last_cyc_q <= 2'h0;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
            unique case (state_q)
                TLXO_ST_IDLE:
                begin
                    if (start_w)
                    begin
                        state_q <= TLXO_ST_EXEC;
                        kind_q <= decode_kind(op_q);
                        cyc_q <= 2'h0;
                        total_q <= (decode_kind(op_q) == TLXO_K_TSTORE) ? CYC_TWO : CYC_ONE;
                    end
                end
                TLXO_ST_EXEC:
                begin
                    if (first_w & (kind_q == TLXO_K_TSKIP) & (phase_q == PH_Q3) &
                        (operand_q == 8'h00))
                        total_q <= two_word_q ? CYC_THREE : CYC_TWO;
                    if (done_w)
                    begin
                        state_q <= TLXO_ST_IDLE;
                        last_cyc_q <= total_q;
                    end
                    else if (end_cyc_w)
                        cyc_q <= cyc_q + 2'h1;
                end
                default:
                    state_q <= TLXO_ST_IDLE;
            endcase
        end
    end

    // data path: q2 read, q3 process, q4 write
    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            wreg_q <= BYTE_RESET;
            ptr_q <= PTR_RESET;
            operand_q <= BYTE_RESET;
            result_q <= BYTE_RESET;
            neg_q <= 1'b0;
            zero_q <= 1'b0;
            skip_q <= 1'b0;
            fr_addr_q <= 12'h000;
            fr_indexed_q <= 1'b0;
            fr_wr_q <= 1'b0;
            fr_wdata_q <= BYTE_RESET;
            flush_q <= 1'b0;
            store_q <= 1'b0;
            store_data_q <= BYTE_RESET;
        end
        else
        begin
            fr_wr_q <= 1'b0;
            store_q <= 1'b0;
            if (wr_w & (paddr_in == ADDR_WREG))
                wreg_q <= pwdata_in[7:0];
            if (wr_w & (paddr_in == ADDR_POINTER))
                ptr_q <= pwdata_in[PTR_W-1:0];
            if (start_w & (decode_kind(op_q) == TLXO_K_TSKIP))
                skip_q <= 1'b0;
            // address valid through q2
            if (first_w & is_file_w & (phase_q == PH_Q1))
            begin
                fr_addr_q <= file_addr(op_q[7:0], op_q[8], bank_q);
                fr_indexed_q <= indexed_w;
            end
            if (first_w & is_file_w & (phase_q == PH_Q2))
                operand_q <= fr_rdata_in;
            if (first_w & (phase_q == PH_Q3))
            begin
                result_q <= xor_w;
                if ((kind_q == TLXO_K_XREG) & to_file_w)
                begin
                    fr_wr_q <= 1'b1;
                    fr_wdata_q <= xor_w;
                end
                if ((kind_q == TLXO_K_TSKIP) & (operand_q == 8'h00))
                    skip_q <= 1'b1;
            end
            if (xor_q4_w)
            begin
                if ((kind_q == TLXO_K_XIMM) | ~to_file_w)
                    wreg_q <= result_q;
                neg_q <= result_q[7];
                zero_q <= (result_q == 8'h00);
            end
            // skipped cycles are no-ops with the prefetch thrown away
            // cleared on the last q4 edge so the flag does not outlive the no-op cycles
            flush_q <= in_exec_w & (kind_q == TLXO_K_TSKIP) & ~done_w &
                       ((cyc_q != 2'h0) | (phase_q == PH_Q4));
            if (store_cyc_w & (phase_q == PH_Q2))
                store_data_q <= latch_q;
            if (store_cyc_w & (phase_q == PH_Q3))
                store_q <= 1'b1;
            // no status flag touched by the table store
            if (pre_inc_w)
                ptr_q <= ptr_q + 21'h000001;
            else if (post_w & (mode_w == MODE_POST_INC))
                ptr_q <= ptr_q + 21'h000001;
            else if (post_w & (mode_w == MODE_POST_DEC))
                ptr_q <= ptr_q - 21'h000001;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign fr_addr_out = fr_addr_q;
    assign fr_indexed_out = fr_indexed_q;
    assign fr_wr_out = fr_wr_q;
    assign fr_wdata_out = fr_wdata_q;
    assign flush_out = flush_q;
    assign prog_start_out = prog_q;

    // byte lane within a word follows pointer bit 0
    wire byte_hi_w = ptr_q[0];

    property p_store_in_q4;
        @(posedge clock_in) disable iff (!nrst_in)
        store_q |-> (phase_q == PH_Q4) && (kind_q == TLXO_K_TSTORE) && (cyc_q == 2'h1);
    endproperty
    a_store_in_q4: assert property (p_store_in_q4) else $error("holding store off q4");

    property p_store_data;
        @(posedge clock_in) disable iff (!nrst_in)
        store_q |-> store_data_q == latch_q;
    endproperty
    a_store_data: assert property (p_store_data) else $error("holding data not latch");

    property p_post_inc;
        @(posedge clock_in) disable iff (!nrst_in)
        (post_w && mode_w == MODE_POST_INC && !wr_w) |=> ptr_q == $past(ptr_q) + 21'h000001;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

    property p_post_dec;
        @(posedge clock_in) disable iff (!nrst_in)
        (post_w && mode_w == MODE_POST_DEC && !wr_w) |=> ptr_q == $past(ptr_q) - 21'h000001;
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post decrement wrong");

    property p_keep_ptr;
        @(posedge clock_in) disable iff (!nrst_in)
        (in_exec_w && kind_q == TLXO_K_TSTORE && mode_w == MODE_KEEP && !wr_w) |=> $stable(ptr_q);
    endproperty
    a_keep_ptr: assert property (p_keep_ptr) else $error("pointer moved in keep mode");

    property p_store_two_cycles;
        @(posedge clock_in) disable iff (!nrst_in)
        (start_w && decode_kind(op_q) == TLXO_K_TSTORE) |->
            ##8 in_exec_w ##1 (state_q == TLXO_ST_IDLE);
    endproperty
    a_store_two_cycles: assert property (p_store_two_cycles) else $error("store not 2 cycles");

    property p_skip_len;
        @(posedge clock_in) disable iff (!nrst_in)
        (first_w && kind_q == TLXO_K_TSKIP && phase_q == PH_Q3 && operand_q == 8'h00
         && !two_word_q) |-> ##1 in_exec_w [*5] ##1 !in_exec_w;
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip not two cycles");

    property p_skip_three;
        @(posedge clock_in) disable iff (!nrst_in)
        (done_w && kind_q == TLXO_K_TSKIP && skip_q && two_word_q) |-> total_q == CYC_THREE;
    endproperty
    a_skip_three: assert property (p_skip_three) else $error("two-word skip not 3");

    property p_zero_flag;
        @(posedge clock_in) disable iff (!nrst_in)
        xor_q4_w |=> (zero_q == ($past(result_q) == 8'h00)) && (neg_q == $past(result_q[7]));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("xor flags wrong");

    property p_file_write;
        @(posedge clock_in) disable iff (!nrst_in)
        fr_wr_q |-> kind_q == TLXO_K_XREG && to_file_w && phase_q == PH_Q4
                    && fr_wdata_q == result_q;
    endproperty
    a_file_write: assert property (p_file_write) else $error("file write misplaced");

    property p_flags_kept;
        @(posedge clock_in) disable iff (!nrst_in)
        (in_exec_w && !xor_kind_w) |=> $stable(neg_q) && $stable(zero_q);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    c_store: cover property (@(posedge clock_in) disable iff (!nrst_in) store_q && byte_hi_w);
    c_skip3: cover property (@(posedge clock_in) disable iff (!nrst_in)
        done_w && total_q == CYC_THREE);
    c_xor_file: cover property (@(posedge clock_in) disable iff (!nrst_in) fr_wr_q);
    c_indexed: cover property (@(posedge clock_in) disable iff (!nrst_in) fr_indexed_q);
endmodule

/* design/tlxo_core_end.sv */
`timescale 1ns/100ps

/* design/tlxo_hold_bank.sv */
// Purpose: eight byte holding registers staged for program memory
// Assumes: store strobe from the executor in the q4 phase
// Notes: contents only stage data; committing is done elsewhere
`timescale 1ns/100ps
module tlxo_hold_bank
    import tlxo_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // executor side
    tlxo_hold_if.bank hold
);
    logic [7:0] mem_q [HOLD_N];

    always_ff @(posedge clock_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < HOLD_N; i++)
                mem_q[i] <= BYTE_RESET;
        end
        else if (hold.store)
        begin
            mem_q[hold.index] <= hold.data;
        end
    end

    always_comb
    begin
        for (int i = 0; i < HOLD_N; i++)
            hold.contents[i*8 +: 8] = mem_q[i];
    end
endmodule

/* design/tlxo_hold_if.sv */
// Purpose: carrier between the executor and the holding register bank
// Assumes: single clock domain
// Notes: store strobe is one clock wide
`timescale 1ns/100ps
interface tlxo_hold_if;
    logic store;
    logic [2:0] index;
    logic [7:0] data;
    logic [63:0] contents;
    modport writer (output store, output index, output data, input contents);
    modport bank (input store, input index, input data, output contents);
endinterface

/* design/tlxo_pkg.sv */
// Purpose: shared constants for the table write and exclusive-or execution block
// Assumes: 32-bit APB register window, 40 MHz core clock, four clocks per instruction cycle
// Notes: all offsets are byte addresses of aligned words
package tlxo_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BANK = 8'h04;
    localparam logic [7:0] ADDR_WREG = 8'h08;
    localparam logic [7:0] ADDR_LATCH = 8'h0C;
    localparam logic [7:0] ADDR_POINTER = 8'h10;
    localparam logic [7:0] ADDR_INSTR = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_HOLD_LO = 8'h1C;
    localparam logic [7:0] ADDR_HOLD_HI = 8'h20;
    localparam logic [7:0] ADDR_PROG = 8'h24;
    // control and status field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_TWO_WORD_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NEG_BIT = 1;
    localparam int STAT_ZERO_BIT = 2;
    localparam int STAT_SKIP_BIT = 3;
    localparam int STAT_CYC_LSB = 4;
    localparam int PROG_START_BIT = 0;
    // widths and reset values
    localparam int PTR_W = 21;
    localparam int HOLD_N = 8;
    localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // pointer modes of the table store opcode
    localparam logic [1:0] MODE_KEEP = 2'h0;
    localparam logic [1:0] MODE_POST_INC = 2'h1;
    localparam logic [1:0] MODE_POST_DEC = 2'h2;
    localparam logic [1:0] MODE_PRE_INC = 2'h3;
    // opcode patterns
    localparam logic [13:0] OPC_TABLE_STORE = 14'h0003;
    localparam logic [7:0] OPC_XOR_IMM = 8'h0A;
    localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
    localparam logic [5:0] OPC_XOR_REG = 6'h06;
    // addressing
    localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // q phases, cycle counts
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [1:0] {
        TLXO_ST_IDLE = 2'b00,
        TLXO_ST_EXEC = 2'b01
    } tlxo_state_t;

    typedef enum logic [2:0] {
        TLXO_K_NONE = 3'b000,
        TLXO_K_TSTORE = 3'b001,
        TLXO_K_XIMM = 3'b010,
        TLXO_K_XREG = 3'b011,
        TLXO_K_TSKIP = 3'b100
    } tlxo_kind_t;
endpackage

/* testbench/table_write_and_logic_ops_tb.sv */
// Purpose: self-checking bench for the executor
// Assumes: one wait state on apb, status busy polled
// Notes: expected reads queued by the driver, checked by the monitor
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module table_write_and_logic_ops_tb import tlxo_pkg::*;;
    logic clock_in = 0, nrst_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, fr_rdata, fr_wdata, w, k, lat, hold[8];
    logic [31:0] pwdata = 0, prdata, r, rnd;
    logic pready, pslverr, fr_wr, fr_idx, flush, prog, nf = 0, zf = 0, flush_d = 0;
    logic [11:0] fr_addr;
    logic [20:0] ptr;
    logic [33:0] e, rdq[$];
    logic [20:0] frq[$];
    logic [15:0] xop[5] = '{16'h1A20, 16'h1A60, 16'h1A10, 16'h1945, 16'h1B5F};
    logic [12:0] xad[5] = '{13'h1020, 13'h0F60, 13'h0010, 13'h0345, 13'h055F};
    int errors = 0, compares = 0, seed = 87069, progs = 0, flushes = 0, flush_clks = 0;
    initial
        forever #12.5 clock_in = ~clock_in;
    tlxo_core dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .fr_addr_out(fr_addr), .fr_indexed_out(fr_idx), .fr_rdata_in(fr_rdata),
        .fr_wr_out(fr_wr), .fr_wdata_out(fr_wdata), .flush_out(flush),
        .prog_start_out(prog));
    tlxo_fr_model mem_u (.clock_in(clock_in), .fr_addr_in(fr_addr), .fr_wr_in(fr_wr),
        .fr_wdata_in(fr_wdata), .fr_rdata_out(fr_rdata));
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        rdq.push_back({1'b1, x});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic stat(input logic [1:0] cyc, input logic skip);
        rd(ADDR_STATUS, {27'h0, cyc, skip, zf, nf, 1'b0});
    endtask
    task automatic exec(input logic [15:0] op);
        apb(1'b1, ADDR_INSTR, {16'h0, op});
        for (int i = 0; i < 40; i++)
        begin
            rdq.push_back(34'h0);
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (r[STAT_BUSY_BIT] === 1'b0)
                return;
        end
        errors++;
        give_verdict();
    endtask
    // monitor: one queued note per read, one per file write
    always @(posedge clock_in)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = rdq.pop_front();
            if (e[33])
                `CHK({pslverr, prdata}, e[32:0])
        end
        if (fr_wr === 1'b1)
        begin
            e = {13'h0, frq.pop_front()};
            `CHK({fr_idx, fr_addr, fr_wdata}, e[20:0])
        end
        if (prog === 1'b1)
            progs++;
        if (flush === 1'b1 && !flush_d)
            flushes++;
        if (flush === 1'b1)
            flush_clks++;
        flush_d <= flush;
    end
    initial
    begin
        for (int i = 0; i < 8; i++)
            hold[i] = 8'h00;
        repeat (10) @(posedge clock_in);
        nrst_in <= 1'b1;
        stat(2'h0, 1'b0);
        rd(ADDR_POINTER, 33'h0);
        rd(8'h28, {1'b1, 32'h0});
        rd(8'h02, {1'b1, 32'h0});
        for (int i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            w = rnd[7:0];
            k = (i == 0) ? w : rnd[15:8];
            apb(1'b1, ADDR_WREG, {24'h0, w});
            exec({OPC_XOR_IMM, k});
            w = w ^ k;
            nf = w[7];
            zf = (w == 8'h00);
            rd(ADDR_WREG, {25'h0, w});
            stat(CYC_ONE, 1'b0);
        end
        for (int i = 0; i < 5; i++)
        begin
            rnd = $random(seed);
            w = rnd[7:0];
            apb(1'b1, ADDR_CTRL, {31'h0, i != 2});
            apb(1'b1, ADDR_BANK, {28'h0, xop[i][8] ? xad[i][11:8] : 4'h9});
            apb(1'b1, ADDR_WREG, {24'h0, w});
            k = w ^ xad[i][7:0];
            nf = k[7];
            zf = (k == 8'h00);
            if (xop[i][9])
                frq.push_back({xad[i], k});
            else
                w = k;
            exec(xop[i]);
            rd(ADDR_WREG, {25'h0, w});
            stat(CYC_ONE, 1'b0);
        end
        // mode 1 starts at the top of the range to see the wrap
        for (int m = 0; m < 4; m++)
        begin
            rnd = $random(seed);
            lat = rnd[31:24];
            ptr = (m == 1) ? 21'h1FFFFF : rnd[20:0];
            apb(1'b1, ADDR_LATCH, {24'h0, lat});
            apb(1'b1, ADDR_POINTER, {11'h0, ptr});
            exec({OPC_TABLE_STORE, m[1:0]});
            if (m == 3)
                ptr = ptr + 1'b1;
            hold[ptr[2:0]] = lat;
            if (m == 1)
                ptr = ptr + 1'b1;
            if (m == 2)
                ptr = ptr - 1'b1;
            rd(ADDR_POINTER, {12'h0, ptr});
            rd(ADDR_HOLD_LO, {1'b0, hold[3], hold[2], hold[1], hold[0]});
            rd(ADDR_HOLD_HI, {1'b0, hold[7], hold[6], hold[5], hold[4]});
            stat(CYC_TWO, 1'b0);
        end
        apb(1'b1, ADDR_PROG, 32'h1);
        rd(ADDR_HOLD_LO, {1'b0, hold[3], hold[2], hold[1], hold[0]});
        apb(1'b1, ADDR_BANK, 32'h4);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, ADDR_CTRL, {30'h0, i != 0, 1'b0});
            exec({8'h67, (i == 2) ? 8'h07 : 8'h00});
            stat((i == 2) ? CYC_ONE : (i == 0) ? CYC_TWO : CYC_THREE, i != 2);
        end
        repeat (4) @(posedge clock_in);
        `CHK(progs, 1)
        `CHK(flushes, 2)
        `CHK(flush_clks, 12)
        `CHK(rdq.size() + frq.size(), 0)
        give_verdict();
    end
endmodule

/* testbench/tlxo_fr_model.sv */
// Purpose: data memory file facing the executor
// Assumes: read is combinational, write lands on the clock edge
// Notes: byte at address i starts as i[7:0]
`timescale 1ns/100ps
module tlxo_fr_model
(
    // clock
    input wire logic clock_in,
    // executor side
    input wire logic [11:0] fr_addr_in,
    input wire logic fr_wr_in,
    input wire logic [7:0] fr_wdata_in,
    output logic [7:0] fr_rdata_out
);
    logic [7:0] mem_q [4096];
    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem_q[i] = i[7:0];
    end
    assign fr_rdata_out = mem_q[fr_addr_in];
    always @(posedge clock_in)
    begin
        if (fr_wr_in)
            mem_q[fr_addr_in] <= fr_wdata_in;
    end
endmodule
